/* inc/sadc_cfg.svh */
// How it works
// - Busy is high exactly while a conversion is in progress.
// - Convert-start counts only while chip select is low, forming the qualified signal.
// - Frame sync is recognised only while chip select is low.
// - Power-down input high resets internal state and enters full power-down.
// - Frame MSB appears without a clock edge; later bits move on rising edges.
// - Read-out advances on serial clock rising edges while chip select is low.
// - Frame sync high at busy fall reloads serial out with the new MSB.
// - Conversion begins, holding the input, promptly after a valid start command.
// - Busy rises promptly after a conversion start command is accepted.
// - Busy drops promptly once the internal conversion completes.
// - An abort command drops busy promptly.
// - Qualified convert-start rising starts sampling promptly.
// - Nap entry takes about 200 ns, full power-down about 10 us.
// - Leaving nap, the converter is ready within 300 ns.
// - External reference resume: 1 ms recovery plus two host conversions.
// - Internal reference resume up to 25 ms, including settling and two conversions.
// - Internal reference settles within 4 ms after power-up or power-down exit.
// - A successful abort enters wait; next read returns 0xFF00.
// - Conversion end with qualified start low enters nap; no sample start enters wait.
// - Chip-select framing: MSB at chip select fall; re-toggle restarts the frame.
// - Frame-sync framing: MSB at frame-sync rise; another rise restarts the frame.
`ifndef SADC_CFG_SVH
`define SADC_CFG_SVH

// ==========================================================
// Clock and timing figures
`define SADC_CLK_NS 20
`define SADC_T_CONV_NS 1100
`define SADC_T_ABORT_NS 1000
`define SADC_T_NAP_ENTER_NS 200
`define SADC_T_NAP_RESUME_NS 300
`define SADC_T_PD_ENTER_NS 10000
`define SADC_T_RECOVER_NS 1000000
`define SADC_T_REF_SETTLE_NS 4000000

// ==========================================================
// Data layout and fixed values
`define SADC_DATA_W 16
`define SADC_MSB 15
`define SADC_ABORT_CODE 16'hFF00
`define SADC_CNT_W 5
`define SADC_TMR_W 18
`define SADC_PINS_RESET 5'h18

`endif

/* inc/sadc_pkg.sv */
package sadc_pkg;

  typedef enum logic [2:0] {
    SADC_ST_SAMPLE,
    SADC_ST_CONVERT,
    SADC_ST_WAIT,
    SADC_ST_NAP,
    SADC_ST_RESUME,
    SADC_ST_PDOWN,
    SADC_ST_RECOVER
  } sadc_state_t;

  // Pin bundle, crossed into the core clock as one word
  typedef struct packed {
    logic cs_n;
    logic convert_start_n;
    logic frame_sync;
    logic power_down_in;
    logic internal_ref;
  } sadc_pins_t;

  typedef struct packed {
    logic busy;
    logic nap;
    logic powered_down;
    logic ref_ready;
  } sadc_status_t;

endpackage

/* logic/sadc_sync.sv */
`timescale 1ns/1ps
module sadc_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RESET_VAL = '0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_q <= RESET_VAL;
      q <= RESET_VAL;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule

/* logic/sadc_ctrl.sv */
`timescale 1ns/1ps
`include "sadc_cfg.svh"
module sadc_ctrl #(
  parameter int CONV_CYC = `SADC_T_CONV_NS / `SADC_CLK_NS,
  parameter int RECOVER_CYC = `SADC_T_RECOVER_NS / `SADC_CLK_NS,
  parameter int REF_SETTLE_CYC = `SADC_T_REF_SETTLE_NS / `SADC_CLK_NS,
  parameter int PD_ENTER_CYC = `SADC_T_PD_ENTER_NS / `SADC_CLK_NS
) (
  // Core clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Host control pins
  input wire logic cs_n,
  input wire logic convert_start_n,
  input wire logic frame_sync,
  input wire logic power_down_in,
  input wire logic internal_ref,
  // Serial clock from host
  input wire logic serial_clk,
  // Conversion result from the SAR array
  input wire logic [`SADC_DATA_W-1:0] sar_result,
  // Device outputs
  output logic busy,
  output logic serial_out,
  output logic serial_out_oe_n,
  output sadc_pkg::sadc_status_t status
);
  import sadc_pkg::*;

  // ==========================================================
  // Derived cycle counts
  localparam int ABORT_CYC = `SADC_T_ABORT_NS / `SADC_CLK_NS;
  localparam int NAP_ENTER_CYC = (`SADC_T_NAP_ENTER_NS + `SADC_CLK_NS - 1) / `SADC_CLK_NS;
  localparam int NAP_RESUME_CYC = `SADC_T_NAP_RESUME_NS / `SADC_CLK_NS;
  localparam int TMR_MAX = (1 << `SADC_TMR_W) - 1;
  localparam logic [`SADC_CNT_W-1:0] FRAME_BITS = `SADC_CNT_W'(`SADC_DATA_W);
  localparam int IDX_W = $clog2(`SADC_DATA_W);

  // Link counter must span two frames, or a wrap would look like a fresh bit
  if ((1 << `SADC_CNT_W) < 2 * `SADC_DATA_W) begin : g_bad_width
    $error("sadc_ctrl: link counter too narrow");
  end

  if (CONV_CYC < 2 || CONV_CYC > TMR_MAX || RECOVER_CYC < 1 || RECOVER_CYC > TMR_MAX ||
      REF_SETTLE_CYC < 1 || REF_SETTLE_CYC > TMR_MAX || PD_ENTER_CYC < 1 ||
      PD_ENTER_CYC > TMR_MAX) begin : g_bad_param
    $error("sadc_ctrl: cycle count out of range");
  end

  localparam logic [`SADC_TMR_W-1:0] CONV_LAST = `SADC_TMR_W'(CONV_CYC - 1);
  localparam logic [`SADC_TMR_W-1:0] ABORT_LIM = `SADC_TMR_W'(ABORT_CYC);
  localparam logic [`SADC_TMR_W-1:0] NAP_ENTER_LIM = `SADC_TMR_W'(NAP_ENTER_CYC);
  localparam logic [`SADC_TMR_W-1:0] NAP_RESUME_LAST = `SADC_TMR_W'(NAP_RESUME_CYC - 1);
  localparam logic [`SADC_TMR_W-1:0] PD_ENTER_LIM = `SADC_TMR_W'(PD_ENTER_CYC);
  localparam logic [`SADC_TMR_W-1:0] RECOVER_LAST = `SADC_TMR_W'(RECOVER_CYC - 1);
  localparam logic [`SADC_TMR_W-1:0] REF_LIM = `SADC_TMR_W'(REF_SETTLE_CYC);

  // ==========================================================
  // Link domain: serial clock edge counter
  // Counts every rising edge in gray code; the core decides which edges
  // belong to a frame, so no control other than reset_n crosses into this domain.
  logic [`SADC_CNT_W-1:0] link_bin_q;
  logic [`SADC_CNT_W-1:0] link_gray_q;
  logic [`SADC_CNT_W-1:0] link_bin_inc;

  assign link_bin_inc = link_bin_q + `SADC_CNT_W'(1);

  always_ff @(posedge serial_clk or negedge reset_n) begin
    if (!reset_n) begin
      link_bin_q <= '0;
      link_gray_q <= '0;
    end else begin
      link_bin_q <= link_bin_inc;
      link_gray_q <= link_bin_inc ^ (link_bin_inc >> 1);
    end
  end

  // ==========================================================
  // Crossings into the core clock
  sadc_pins_t pins_raw;
  sadc_pins_t pins_s;
  logic [`SADC_CNT_W-1:0] gray_s;

  assign pins_raw = '{cs_n: cs_n, convert_start_n: convert_start_n, frame_sync: frame_sync,
                      power_down_in: power_down_in, internal_ref: internal_ref};

  sadc_sync #(.W($bits(sadc_pins_t)), .RESET_VAL(`SADC_PINS_RESET)) u_pin_sync (
    .clk(clk),
    .reset_n(reset_n),
    .d(pins_raw),
    .q(pins_s)
  );

  // Gray code changes one bit per edge, so a word crossing is safe here
  sadc_sync #(.W(`SADC_CNT_W), .RESET_VAL('0)) u_cnt_sync (
    .clk(clk),
    .reset_n(reset_n),
    .d(link_gray_q),
    .q(gray_s)
  );

  function automatic logic [`SADC_CNT_W-1:0] gray2bin(input logic [`SADC_CNT_W-1:0] g);
    logic [`SADC_CNT_W-1:0] b;
    b = '0;
    b[`SADC_CNT_W-1] = g[`SADC_CNT_W-1];
    for (int i = `SADC_CNT_W - 2; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction

  // ==========================================================
  // Qualified convert-start and edge decode
  logic cs_prev_q;
  logic fs_prev_q;
  logic qual_q;
  logic qual_d;
  logic cs_low;
  logic pd_on;
  logic conv_cmd;
  logic sample_cmd;
  logic cs_fall;
  logic fs_rise;

  assign cs_low = ~pins_s.cs_n;
  assign pd_on = pins_s.power_down_in;
  // Transparent while chip select is low, holds while it is high
  assign qual_d = cs_low ? pins_s.convert_start_n : qual_q;
  assign conv_cmd = qual_q & ~qual_d;
  assign sample_cmd = qual_d & cs_low;
  assign cs_fall = cs_prev_q & cs_low;
  assign fs_rise = ~fs_prev_q & pins_s.frame_sync & cs_low;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cs_prev_q <= 1'b1;
      fs_prev_q <= 1'b0;
      qual_q <= 1'b1;
    end else begin
      cs_prev_q <= pins_s.cs_n;
      fs_prev_q <= pins_s.frame_sync;
      qual_q <= pd_on ? 1'b1 : qual_d;
    end
  end

  // ==========================================================
  // Conversion state machine
  sadc_state_t state_q;
  sadc_state_t state_d;
  logic [`SADC_TMR_W-1:0] tmr_q;
  logic [`SADC_DATA_W-1:0] result_q;
  logic [`SADC_DATA_W-1:0] result_d;
  logic conv_done;
  logic conv_abort;
  logic busy_fall;

  assign conv_done = (state_q == SADC_ST_CONVERT) && (tmr_q == CONV_LAST);
  // Start edges after the abort window are ignored
  assign conv_abort = (state_q == SADC_ST_CONVERT) && conv_cmd && (tmr_q < ABORT_LIM);
  assign busy_fall = conv_done | conv_abort;
  assign result_d = conv_abort ? `SADC_ABORT_CODE :
                    conv_done ? sar_result : result_q;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      SADC_ST_SAMPLE: begin
        if (conv_cmd) begin
          state_d = SADC_ST_CONVERT;
        end
      end
      SADC_ST_CONVERT: begin
        if (conv_abort) begin
          state_d = SADC_ST_WAIT;
        end else if (conv_done) begin
          if (sample_cmd) begin
            state_d = SADC_ST_SAMPLE;
          end else if (!qual_d) begin
            state_d = SADC_ST_NAP;
          end else begin
            state_d = SADC_ST_WAIT;
          end
        end
      end
      SADC_ST_WAIT: begin
        if (sample_cmd) begin
          state_d = SADC_ST_SAMPLE;
        end
      end
      SADC_ST_NAP: begin
        if (sample_cmd) begin
          state_d = SADC_ST_RESUME;
        end
      end
      SADC_ST_RESUME: begin
        if (tmr_q == NAP_RESUME_LAST) begin
          state_d = SADC_ST_SAMPLE;
        end
      end
      SADC_ST_PDOWN: begin
        if (!pd_on) begin
          state_d = SADC_ST_RECOVER;
        end
      end
      SADC_ST_RECOVER: begin
        if (tmr_q == RECOVER_LAST) begin
          state_d = SADC_ST_WAIT;
        end
      end
    endcase
    if (pd_on) begin
      state_d = SADC_ST_PDOWN;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= SADC_ST_WAIT;
      tmr_q <= '0;
      result_q <= '0;
    end else begin
      state_q <= state_d;
      tmr_q <= (state_d != state_q || tmr_q == TMR_MAX[`SADC_TMR_W-1:0]) ? '0 : tmr_q + 1'b1;
      result_q <= pd_on ? '0 : result_d;
    end
  end

  // ==========================================================
  // Status: busy, nap, power-down and reference settling
  logic [`SADC_TMR_W-1:0] ref_tmr_q;
  logic ref_settled;
  logic busy_q;
  sadc_status_t status_q;

  assign ref_settled = ref_tmr_q >= REF_LIM;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ref_tmr_q <= '0;
    end else if (pd_on) begin
      ref_tmr_q <= '0;
    end else if (!ref_settled) begin
      ref_tmr_q <= ref_tmr_q + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      busy_q <= 1'b0;
      status_q <= '0;
    end else begin
      busy_q <= (state_d == SADC_ST_CONVERT);
      status_q.busy <= (state_d == SADC_ST_CONVERT);
      status_q.nap <= (state_q == SADC_ST_NAP) && (tmr_q >= NAP_ENTER_LIM);
      status_q.powered_down <= (state_q == SADC_ST_PDOWN) && (tmr_q >= PD_ENTER_LIM);
      status_q.ref_ready <= ~pd_on & (ref_settled | ~pins_s.internal_ref);
    end
  end

  // ==========================================================
  // Serial read-out
  logic [`SADC_CNT_W-1:0] cnt_bin;
  logic [`SADC_CNT_W-1:0] base_q;
  logic [`SADC_CNT_W-1:0] bit_idx;
  logic [`SADC_CNT_W-1:0] bit_pos;
  logic [`SADC_DATA_W-1:0] frame_q;
  logic frame_load;
  logic frame_reload;
  logic shift_bit;
  logic sdo_q;
  logic sdo_oe_n_q;
  logic past_end;
  logic frame_over_q;

  assign cnt_bin = gray2bin(gray_s);
  assign bit_idx = cnt_bin - base_q;
  assign bit_pos = `SADC_CNT_W'(`SADC_MSB) - bit_idx;
  // Sticky, so a wrap of the link counter never replays old bits
  assign past_end = frame_over_q | (bit_idx >= FRAME_BITS);
  assign shift_bit = past_end ? 1'b0 : frame_q[bit_pos[IDX_W-1:0]];
  // New result's MSB on busy fall when frame sync is held high
  assign frame_reload = busy_fall & pins_s.frame_sync & cs_low;
  assign frame_load = cs_fall | fs_rise | frame_reload;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      base_q <= '0;
      frame_q <= '0;
      sdo_q <= 1'b0;
      sdo_oe_n_q <= 1'b1;
    end else if (pd_on || !cs_low) begin
      base_q <= cnt_bin;
      sdo_q <= 1'b0;
      sdo_oe_n_q <= 1'b1;
    end else if (frame_load) begin
      base_q <= cnt_bin;
      frame_q <= result_d;
      sdo_q <= result_d[`SADC_MSB];
      sdo_oe_n_q <= 1'b0;
    end else begin
      sdo_q <= shift_bit;
      sdo_oe_n_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      frame_over_q <= 1'b0;
    end else if (pd_on || !cs_low || frame_load) begin
      frame_over_q <= 1'b0;
    end else begin
      frame_over_q <= past_end;
    end
  end

  assign busy = busy_q;
  assign serial_out = sdo_q;
  assign serial_out_oe_n = sdo_oe_n_q;
  assign status = status_q;

endmodule

/* verification/sadc_checker.sv */
`timescale 1ns/1ps
module sadc_checker #(
  parameter int CONV_CYC = 55,
  parameter int PD_ENTER_CYC = 500
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Host pins
  input wire logic cs_n,
  input wire logic power_down_in,
  // Device outputs
  input wire logic busy,
  input wire logic serial_out_oe_n,
  input wire sadc_pkg::sadc_status_t status
);
  import sadc_pkg::*;
  // ==========
  // Run lengths
  logic [15:0] busy_cnt_q;
  logic [15:0] pd_cnt_q;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      busy_cnt_q <= 16'h0000;
      pd_cnt_q <= 16'h0000;
    end else begin
      busy_cnt_q <= busy ? busy_cnt_q + 16'h0001 : 16'h0000;
      pd_cnt_q <= power_down_in ? pd_cnt_q + 16'h0001 : 16'h0000;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // ==========
  // Properties
  a_busy_length: assert property (busy |-> busy_cnt_q < CONV_CYC)
    else $error("busy too long");
  a_start_needs_cs: assert property (
    $rose(busy) |-> !$past(cs_n, 2) || !$past(cs_n, 3) || !$past(cs_n, 4) || !$past(cs_n, 5))
    else $error("start without select");
  a_cs_float: assert property (cs_n [*5] |-> serial_out_oe_n)
    else $error("output driven while deselected");
  a_pd_float: assert property (power_down_in [*5] |-> serial_out_oe_n && !busy)
    else $error("active in power-down");
  a_pd_no_ref: assert property (power_down_in [*6] |-> !status.ref_ready)
    else $error("reference ready in power-down");
  a_msb_on_cs: assert property ($fell(cs_n) && !power_down_in |-> ##[1:5] !serial_out_oe_n)
    else $error("no frame on select");
  a_nap_idle: assert property (status.nap |-> !busy)
    else $error("nap while busy");
  a_pd_entry_time: assert property ($rose(status.powered_down) |-> pd_cnt_q >= PD_ENTER_CYC)
    else $error("power-down too early");
  a_pd_entry_bound: assert property (pd_cnt_q == PD_ENTER_CYC + 6 |-> status.powered_down)
    else $error("power-down too late");
  c_abort: cover property ($fell(busy) && busy_cnt_q < CONV_CYC - 2);
  c_nap: cover property ($rose(status.nap));
  c_pdown: cover property ($rose(status.powered_down));
endmodule

bind sadc_ctrl sadc_checker #(.CONV_CYC(CONV_CYC), .PD_ENTER_CYC(PD_ENTER_CYC)) u_sadc_checker (
  .clk, .reset_n, .cs_n, .power_down_in, .busy, .serial_out_oe_n, .status);

/* verification/sadc_host.sv */
`timescale 1ns/1ps
module sadc_host (
  // Pacing clock
  input wire logic clk,
  // Device outputs
  input wire logic serial_out,
  input wire logic serial_out_oe_n,
  // Host pins
  output logic cs_n,
  output logic convert_start_n,
  output logic frame_sync,
  output logic power_down_in,
  output logic serial_clk
);
  // ==========
  // Idle levels, serial clock still outside frames
  initial begin
    cs_n = 1'b1;
    convert_start_n = 1'b1;
    frame_sync = 1'b1;
    power_down_in = 1'b0;
    serial_clk = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // ==========
  // Select-framed read, leaves select low
  task automatic read(output logic [15:0] w, output logic drv);
    drv = 1'b1;
    cs_n = 1'b1;
    tick(4);
    cs_n = 1'b0;
    tick(5);
    for (int i = 15; i >= 0; i--) begin
      if (i < 15) begin
        // 6 ns high pulse in a 120 ns link period, clear of the core edge
        #4 serial_clk = 1'b1;
        #6 serial_clk = 1'b0;
        tick(6);
      end
      // Taken well after the launching rise
      w[i] = serial_out;
      drv = drv & (serial_out_oe_n === 1'b0);
    end
  endtask
endmodule

/* verification/tb_sar_adc_serial_control.sv */
`timescale 1ns/1ps
module tb_sar_adc_serial_control;
  import sadc_pkg::*;
  localparam int CONV_C = 20;
  localparam int PD_C = 10;
  localparam int REC_C = 20;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic internal_ref = 1'b0;
  logic [15:0] sar_result = 16'h0000;
  logic cs_n, convert_start_n, frame_sync, power_down_in, serial_clk;
  logic busy, serial_out, serial_out_oe_n, drv;
  logic [15:0] word;
  sadc_status_t status;
  int bad_count = 0;
  int checks_done = 0;
  int cyc = 0;
  always #10 clk = ~clk;
  sadc_ctrl #(.CONV_CYC(CONV_C), .RECOVER_CYC(REC_C), .REF_SETTLE_CYC(30), .PD_ENTER_CYC(PD_C))
    u_sadc_ctrl (.clk(clk), .reset_n(reset_n), .cs_n(cs_n), .convert_start_n(convert_start_n),
    .frame_sync(frame_sync), .power_down_in(power_down_in), .internal_ref(internal_ref),
    .serial_clk(serial_clk), .sar_result(sar_result), .busy(busy), .serial_out(serial_out),
    .serial_out_oe_n(serial_out_oe_n), .status(status));
  sadc_host u_sadc_host (.clk(clk), .serial_out(serial_out), .serial_out_oe_n(serial_out_oe_n),
    .cs_n(cs_n), .convert_start_n(convert_start_n), .frame_sync(frame_sync),
    .power_down_in(power_down_in), .serial_clk(serial_clk));
  // ==========
  // Helpers
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    chk_word({15'h0000, got}, {15'h0000, exp});
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // ==========
  // Scenarios
  task automatic t_nap_conv;
    int m;
    int n;
    m = 0;
    n = 0;
    sar_result = 16'hA5C3;
    u_sadc_host.cs_n = 1'b0;
    tick(4);
    u_sadc_host.convert_start_n = 1'b0;
    while (busy !== 1'b1 && m < 10) begin
      tick(1);
      m++;
    end
    chk_bit(m < 5, 1'b1);
    while (busy === 1'b1 && n < 100) begin
      tick(1);
      n++;
    end
    chk_word(16'(n), 16'(CONV_C));
    tick(3);
    chk_bit(serial_out, 1'b1);
    tick(15);
    chk_bit(status.nap, 1'b1);
    u_sadc_host.convert_start_n = 1'b1;
    tick(18);
    chk_bit(status.nap, 1'b0);
    u_sadc_host.read(word, drv);
    chk_word(word, 16'hA5C3);
    chk_bit(drv, 1'b1);
    $display("test nap_conv done");
  endtask
  task automatic t_abort;
    sar_result = 16'h1234;
    u_sadc_host.convert_start_n = 1'b0;
    tick(5);
    chk_bit(busy, 1'b1);
    u_sadc_host.convert_start_n = 1'b1;
    tick(3);
    u_sadc_host.convert_start_n = 1'b0;
    tick(6);
    // Well before a full conversion could end
    chk_bit(busy, 1'b0);
    u_sadc_host.convert_start_n = 1'b1;
    tick(4);
    u_sadc_host.read(word, drv);
    chk_word(word, 16'hFF00);
    $display("test abort done");
  endtask
  task automatic t_fs_frame;
    u_sadc_host.frame_sync = 1'b0;
    tick(3);
    chk_bit(serial_out, 1'b0);
    u_sadc_host.frame_sync = 1'b1;
    tick(4);
    chk_bit(serial_out, 1'b1);
    $display("test fs_frame done");
  endtask
  task automatic t_cs_high;
    u_sadc_host.cs_n = 1'b1;
    tick(5);
    chk_bit(serial_out_oe_n, 1'b1);
    u_sadc_host.convert_start_n = 1'b0;
    tick(8);
    chk_bit(busy, 1'b0);
    u_sadc_host.frame_sync = 1'b0;
    tick(3);
    u_sadc_host.frame_sync = 1'b1;
    tick(5);
    chk_bit(serial_out_oe_n, 1'b1);
    u_sadc_host.convert_start_n = 1'b1;
    tick(2);
    $display("test cs_high done");
  endtask
  task automatic t_pdown;
    internal_ref = 1'b1;
    u_sadc_host.power_down_in = 1'b1;
    tick(5);
    chk_bit(serial_out_oe_n, 1'b1);
    chk_bit(busy, 1'b0);
    tick(PD_C + 4);
    chk_bit(status.powered_down, 1'b1);
    chk_bit(status.ref_ready, 1'b0);
    u_sadc_host.power_down_in = 1'b0;
    tick(3);
    // Start edge while still recovering must be refused
    u_sadc_host.cs_n = 1'b0;
    u_sadc_host.convert_start_n = 1'b0;
    tick(REC_C + 5);
    chk_bit(busy, 1'b0);
    u_sadc_host.convert_start_n = 1'b1;
    tick(2);
    chk_bit(status.ref_ready, 1'b0);
    u_sadc_host.read(word, drv);
    chk_word(word, 16'h0000);
    chk_bit(status.ref_ready, 1'b1);
    sar_result = 16'h3C96;
    // Host cycles convert-start twice before trusting a result
    repeat (2) begin
      u_sadc_host.convert_start_n = 1'b0;
      tick(4);
      chk_bit(busy, 1'b1);
      u_sadc_host.convert_start_n = 1'b1;
      tick(CONV_C + 4);
    end
    u_sadc_host.read(word, drv);
    chk_word(word, 16'h3C96);
    $display("test pdown done");
  endtask
  // ==========
  // Main sequence and hang guard
  initial begin
    tick(3);
    reset_n = 1'b1;
    tick(3);
    t_nap_conv();
    t_abort();
    t_fs_frame();
    t_cs_high();
    t_pdown();
    close_out();
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      bad_count++;
      close_out();
    end
  end
endmodule
